// ---- mct_pkg.sv ----
/*
 * Package of the main clock, timebase and tone unit: register indices,
 * field layout, reset values, divider counts and the mode enumeration.
 * Assumes a single 10 MHz system clock that stands for the oscillator clock.
 */
package mct_pkg;
	// Register indices; the byte address on the bus is four times the index
	localparam logic [5:0] IDX_CCS      = 6'h2C;
	localparam logic [5:0] IDX_TONE     = 6'h2D;
	localparam logic [5:0] IDX_INT_STAT = 6'h2E;
	localparam logic [5:0] IDX_INT_MASK = 6'h2F;

	// Field positions
	localparam int CCS_CLKOUT_BIT = 7;
	localparam int CCS_FLAG_BIT   = 0;
	localparam int TONE_FIELD_MSB = 1;
	localparam int INT_TB_BIT     = 0;
	localparam int INT_WAKE_BIT   = 1;
	localparam int INT_BITS       = 2;

	// Reset values
	localparam logic [7:0]          CCS_RST  = 8'h00;
	localparam logic [7:0]          TONE_RST = 8'h00;
	localparam logic [INT_BITS-1:0] INT_RST  = 2'h0;

	// Timebase periods in oscillator cycles, per timebase field code
	localparam int unsigned TB_DIV0 = 16000;
	localparam int unsigned TB_DIV1 = 32000;
	localparam int unsigned TB_DIV2 = 80000;
	localparam int unsigned TB_DIV3 = 200000;

	// Tone frequencies, defined against an 8 MHz reference oscillator
	localparam int unsigned TONE_REF_HZ = 8000000;
	localparam int unsigned TONE_F1_HZ  = 2000;
	localparam int unsigned TONE_F2_HZ  = 1000;
	localparam int unsigned TONE_F3_HZ  = 500;
	localparam int unsigned TONE_HALF1  = TONE_REF_HZ / (2 * TONE_F1_HZ);
	localparam int unsigned TONE_HALF2  = TONE_REF_HZ / (2 * TONE_F2_HZ);
	localparam int unsigned TONE_HALF3  = TONE_REF_HZ / (2 * TONE_F3_HZ);

	// Control and status register layout
	typedef struct packed {
		logic       clock_out_select;
		logic [1:0] slow_divider_field;
		logic       slow_select;
		logic [1:0] timebase_field;
		logic       timebase_irq_enable;
		logic       timebase_flag;
	} mct_ccs_t;

	typedef enum logic [1:0] {
		MD_RUN,
		MD_ACTIVE_HALT,
		MD_HALT
	} mct_mode_t;
endpackage

// ---- mct_top.sv ----
/*
 * Main clock controller: slow-mode core clock divider, clock-out pin,
 * periodic timebase with flag and interrupt, tone generator, halt mode
 * selection, Avalon-MM register slave.
 * Assumes sys_clk_in is the oscillator clock; the CPU drives halt_exec_in,
 * wait_in and irq_mask_in on the same clock; ext_wake_in is asynchronous.
 */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module mct_top
	import mct_pkg::*;
#(
	parameter int unsigned TB_PERIOD0 = TB_DIV0,
	parameter int unsigned TB_PERIOD1 = TB_DIV1,
	parameter int unsigned TB_PERIOD2 = TB_DIV2,
	parameter int unsigned TB_PERIOD3 = TB_DIV3,
	parameter int unsigned TONE_HALF_1 = TONE_HALF1,
	parameter int unsigned TONE_HALF_2 = TONE_HALF2,
	parameter int unsigned TONE_HALF_3 = TONE_HALF3
) (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// CPU power and interrupt status
	input  wire logic        halt_exec_in,
	input  wire logic        wait_in,
	input  wire logic        irq_mask_in,
	input  wire logic        ext_wake_in,
	// Clocks, pins and mode outputs
	output logic             core_tick_out,
	output logic             clock_out_pin_out,
	output logic             clock_out_pin_oe_out,
	output logic             tone_pin_out,
	output logic             tone_pin_oe_out,
	output logic             active_halt_out,
	output logic             halt_out,
	output logic             wake_out,
	output logic             irq_out
);
	localparam int TB_W = $clog2(TB_PERIOD3 + 1);
	localparam int TN_W = $clog2(TONE_HALF_3 + 1);

	if (TB_PERIOD0 < 2 || TB_PERIOD1 < TB_PERIOD0 || TB_PERIOD2 < TB_PERIOD1 ||
		TB_PERIOD3 < TB_PERIOD2) begin : g_tb_chk
		$error("Timebase periods must be at least 2 and ascending");
	end
	if (TONE_HALF_1 < 1 || TONE_HALF_2 < TONE_HALF_1 || TONE_HALF_3 < TONE_HALF_2) begin : g_tn_chk
		$error("Tone half periods must be at least 1 and ascending");
	end

	function automatic logic [TB_W-1:0] tb_last(input logic [1:0] code);
		case (code)
			2'd0:    tb_last = TB_W'(TB_PERIOD0 - 1);
			2'd1:    tb_last = TB_W'(TB_PERIOD1 - 1);
			2'd2:    tb_last = TB_W'(TB_PERIOD2 - 1);
			default: tb_last = TB_W'(TB_PERIOD3 - 1);
		endcase
	endfunction

	function automatic logic [3:0] div_last(input logic [1:0] code);
		div_last = 4'((5'h2 << code) - 5'h1);
	endfunction

	// Registers
	mct_ccs_t            ccs_r;
	logic [1:0]          tone_field_r;
	logic [INT_BITS-1:0] int_stat_r;
	logic [INT_BITS-1:0] int_mask_r;
	logic                wreq_r;
	logic [31:0]         rdata_r;
	mct_mode_t           mode_r;
	mct_mode_t           mode_nxt;
	logic [3:0]          div_cnt_r;
	logic                core_tick_r;
	logic                clkout_r;
	logic                clkout_oe_r;
	logic [TB_W-1:0]     tb_cnt_r;
	logic [1:0]          tb_sel_r;
	logic [TN_W-1:0]     tone_cnt_r;
	logic                tone_r;
	logic                tone_oe_r;
	logic                ah_r;
	logic                halt_r;
	logic                wake_r;
	logic                irq_r;
	logic                wake_meta_r;
	logic                wake_sync_r;

	// Bus decode
	wire logic [5:0] idx      = avs_address_in[7:2];
	wire logic       req      = avs_read_in | avs_write_in;
	wire logic       accept   = req & ~wreq_r;
	wire logic       running  = (mode_r == MD_RUN);
	wire logic       wr_ok    = accept & avs_write_in & avs_byteenable_in[0] & running;
	wire logic       wr_ccs   = wr_ok & (idx == IDX_CCS);
	wire logic       wr_tone  = wr_ok & (idx == IDX_TONE);
	wire logic       wr_stat  = wr_ok & (idx == IDX_INT_STAT);
	wire logic       wr_mask  = wr_ok & (idx == IDX_INT_MASK);
	wire logic       rd_clear = accept & avs_read_in & (idx == IDX_CCS) & running;
	wire logic [7:0] wbyte    = avs_writedata_in[7:0];

	// Read multiplexer; unmapped addresses read zero
	wire logic [7:0] rd_byte =
		(idx == IDX_CCS)      ? ccs_r :
		(idx == IDX_TONE)     ? {6'h0, tone_field_r} :
		(idx == IDX_INT_STAT) ? {6'h0, int_stat_r} :
		(idx == IDX_INT_MASK) ? {6'h0, int_mask_r} : 8'h00;

	// Timebase: runs except in full halt
	wire logic       tb_run  = (mode_r != MD_HALT);
	wire logic       tb_tick = tb_run & (tb_cnt_r == tb_last(tb_sel_r));

	// Core clock divider
	wire logic       div_hit  = (div_cnt_r == div_last(ccs_r.slow_divider_field));
	wire logic       core_nxt = running & (~ccs_r.slow_select | div_hit);

	// Tone divider
	wire logic [TN_W-1:0] tone_last =
		(tone_field_r == 2'd1) ? TN_W'(TONE_HALF_1 - 1) :
		(tone_field_r == 2'd2) ? TN_W'(TONE_HALF_2 - 1) : TN_W'(TONE_HALF_3 - 1);
	wire logic tone_on  = (tone_field_r != 2'd0);
	wire logic tone_hit = (tone_cnt_r == tone_last);

	// Interrupt events
	wire logic tb_event = tb_tick & ccs_r.timebase_irq_enable;
	wire logic wake_nxt = ((mode_r == MD_ACTIVE_HALT) & (tb_event | wake_sync_r)) |
		((mode_r == MD_HALT) & wake_sync_r) | (running & wait_in & tb_event);
	wire logic [INT_BITS-1:0] int_set = {wake_nxt, tb_event};
	wire logic [INT_BITS-1:0] int_clr = wr_stat ? wbyte[INT_BITS-1:0] : '0;
	wire logic [INT_BITS-1:0] int_stat_nxt = (int_stat_r & ~int_clr) | int_set;

	// Mode sequencing
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			MD_RUN: begin
				if (halt_exec_in) begin
					mode_nxt = ccs_r.timebase_irq_enable ? MD_ACTIVE_HALT : MD_HALT;
				end
			end
			MD_ACTIVE_HALT: begin
				if (tb_event | wake_sync_r) begin
					mode_nxt = MD_RUN;
				end
			end
			MD_HALT: begin
				if (wake_sync_r) begin
					mode_nxt = MD_RUN;
				end
			end
			default: mode_nxt = MD_RUN;
		endcase
	end

	// Wake source synchroniser
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			wake_meta_r <= 1'b0;
			wake_sync_r <= 1'b0;
		end else begin
			wake_meta_r <= ext_wake_in;
			wake_sync_r <= wake_meta_r;
		end
	end

	// Bus handshake: one wait cycle, read data loaded as waitrequest drops
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			wreq_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wreq_r <= ~(req & wreq_r);
			if (avs_read_in & wreq_r) begin
				rdata_r <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Control registers; bus writes blocked outside run mode, timebase flag still set in active halt
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ccs_r        <= CCS_RST;
			tone_field_r <= TONE_RST[TONE_FIELD_MSB:0];
			int_mask_r   <= INT_RST;
		end else begin
			if (wr_ccs) begin
				ccs_r[7:1] <= wbyte[7:1];
			end
			// Hardware set wins over the read clear
			if (tb_tick) begin
				ccs_r.timebase_flag <= 1'b1;
			end else if (rd_clear) begin
				ccs_r.timebase_flag <= 1'b0;
			end
			if (wr_tone) begin
				tone_field_r <= wbyte[TONE_FIELD_MSB:0];
			end
			if (wr_mask) begin
				int_mask_r <= wbyte[INT_BITS-1:0];
			end
		end
	end

	// Interrupt status, mode and wake
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			int_stat_r <= INT_RST;
			irq_r      <= 1'b0;
			mode_r     <= MD_RUN;
			ah_r       <= 1'b0;
			halt_r     <= 1'b0;
			wake_r     <= 1'b0;
		end else begin
			int_stat_r <= int_stat_nxt;
			irq_r      <= (|(int_stat_r & int_mask_r)) & ~irq_mask_in;
			mode_r     <= mode_nxt;
			ah_r       <= (mode_nxt == MD_ACTIVE_HALT);
			halt_r     <= (mode_nxt == MD_HALT);
			wake_r     <= wake_nxt;
		end
	end

	// Timebase counter; new selection loaded only at period end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			tb_cnt_r <= '0;
			tb_sel_r <= 2'd0;
		end else if (tb_tick) begin
			tb_cnt_r <= '0;
			tb_sel_r <= ccs_r.timebase_field;
		end else if (tb_run) begin
			tb_cnt_r <= tb_cnt_r + TB_W'(1);
		end
	end

	// Core clock and clock-out; clock-out toggles per core tick, so it runs at half core rate
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			div_cnt_r   <= 4'h0;
			core_tick_r <= 1'b0;
			clkout_r    <= 1'b0;
			clkout_oe_r <= 1'b0;
		end else begin
			if (!running || div_hit || !ccs_r.slow_select) begin
				div_cnt_r <= 4'h0;
			end else begin
				div_cnt_r <= div_cnt_r + 4'h1;
			end
			core_tick_r <= core_nxt;
			clkout_oe_r <= ccs_r.clock_out_select;
			if (!ccs_r.clock_out_select) begin
				clkout_r <= 1'b0;
			end else if (core_nxt) begin
				clkout_r <= ~clkout_r;
			end
		end
	end

	// Tone generator; keeps running in active halt
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			tone_cnt_r <= '0;
			tone_r     <= 1'b0;
			tone_oe_r  <= 1'b0;
		end else begin
			tone_oe_r <= tone_on;
			if (!tone_on) begin
				tone_cnt_r <= '0;
				tone_r     <= 1'b0;
			end else if (mode_r != MD_HALT) begin
				tone_cnt_r <= tone_hit ? '0 : tone_cnt_r + TN_W'(1);
				if (tone_hit) begin
					tone_r <= ~tone_r;
				end
			end
		end
	end

	assign avs_readdata_out     = rdata_r;
	assign avs_waitrequest_out  = wreq_r;
	assign core_tick_out        = core_tick_r;
	assign clock_out_pin_out    = clkout_r;
	assign clock_out_pin_oe_out = clkout_oe_r;
	assign tone_pin_out         = tone_r;
	assign tone_pin_oe_out      = tone_oe_r;
	assign active_halt_out      = ah_r;
	assign halt_out             = halt_r;
	assign wake_out             = wake_r;
	assign irq_out              = irq_r;

	// Checking helpers: spacing of core ticks and timebase expiries
	logic [3:0]      gap_r;
	logic            gap_ok_r;
	logic [TB_W-1:0] tb_gap_r;
	logic            tb_seen_r;
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			gap_r     <= 4'h0;
			gap_ok_r  <= 1'b0;
			tb_gap_r  <= '0;
			tb_seen_r <= 1'b0;
		end else begin
			gap_r     <= core_tick_r ? 4'h0 : gap_r + 4'h1;
			gap_ok_r  <= (core_tick_r | gap_ok_r) & ~wr_ccs & running;
			tb_gap_r  <= tb_tick ? '0 : tb_gap_r + TB_W'(1);
			tb_seen_r <= (tb_tick | tb_seen_r) & tb_run;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_halt_req;
		running && halt_exec_in;
	endsequence
	sequence s_enter_ah;
		ah_r && !halt_r;
	endsequence

	AST_DIV_RATIO: assert property (core_tick_r && gap_ok_r && ccs_r.slow_select && running
		|-> gap_r == div_last(ccs_r.slow_divider_field))
		else $error("Slow core tick spacing wrong");
	AST_FULL_RATE: assert property (running && !ccs_r.slow_select && $past(running)
		|=> core_tick_r)
		else $error("Core tick missing at full rate");
	AST_CLKOUT_REL: assert property (!ccs_r.clock_out_select |=> !clkout_oe_r && !clkout_r)
		else $error("Clock-out pin not released");
	AST_CLKOUT_STOP: assert property (mode_r == MD_ACTIVE_HALT |=> $stable(clkout_r))
		else $error("Clock-out toggled in active halt");
	AST_TB_PERIOD: assert property (tb_tick && tb_seen_r |-> tb_gap_r == tb_last(tb_sel_r))
		else $error("Timebase period wrong");
	AST_TB_SEL: assert property (!tb_tick |=> $stable(tb_sel_r))
		else $error("Timebase selection changed mid-period");
	AST_FLAG_SET: assert property (tb_tick |=> ccs_r.timebase_flag)
		else $error("Timebase flag not set");
	AST_FLAG_CLR: assert property (rd_clear && !tb_tick |=> !ccs_r.timebase_flag)
		else $error("Timebase flag not cleared by read");
	AST_IRQ_MASK: assert property (irq_mask_in |=> !irq_r)
		else $error("Interrupt raised under global mask");
	AST_AH_ENTRY: assert property (s_halt_req ##0 ccs_r.timebase_irq_enable |=> s_enter_ah)
		else $error("Active halt not entered");
	AST_AH_WAKE: assert property (mode_r == MD_ACTIVE_HALT && tb_event
		|=> running ##0 wake_r)
		else $error("Timebase did not wake active halt");
	AST_HALT_FREEZE: assert property (mode_r == MD_HALT |=> $stable(tb_cnt_r))
		else $error("Timebase counted in halt");
	AST_TONE_OFF: assert property (!tone_on |=> !tone_r && !tone_oe_r)
		else $error("Tone active while off");
endmodule

// ---- mct_pin_monitor.sv ----
/*
 * External loads on the clock-out and tone pins: count edges, measure tone half period.
 * Assumes the pins are sampled on the unit's own clock; an undriven pin reads low.
 */
`timescale 1ns/1ns
module mct_pin_monitor (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	// Observed pins
	input  wire logic        clk_pin_in,
	input  wire logic        tone_pin_in,
	// Measurements
	output logic [15:0]      clk_edges_out,
	output logic [15:0]      tone_edges_out,
	output logic [15:0]      tone_half_out
);
	logic        clk_last_r;
	logic        tone_last_r;
	logic [15:0] tone_run_r;

	always_ff @(posedge clk_in) begin
		clk_last_r  <= clk_pin_in;
		tone_last_r <= tone_pin_in;
		if (!rstn_in) begin
			clk_edges_out  <= 16'h0000;
			tone_edges_out <= 16'h0000;
			tone_half_out  <= 16'h0000;
			tone_run_r     <= 16'h0000;
		end else begin
			if (clk_pin_in != clk_last_r) clk_edges_out <= clk_edges_out + 16'h0001;
			if (tone_pin_in != tone_last_r) begin
				tone_edges_out <= tone_edges_out + 16'h0001;
				tone_half_out  <= tone_run_r + 16'h0001;
				tone_run_r     <= 16'h0000;
			end else begin
				tone_run_r <= tone_run_r + 16'h0001;
			end
		end
	end
endmodule

// ---- mct_top_tb.sv ----
/*
 * Self-checking bench of the clock, timebase and tone unit.
 * Assumes shortened timebase counts and a shortened first tone count set
 * through the parameters; the two slower tones keep their real half periods.
 */
`timescale 1ns/1ns
module mct_top_tb
	import mct_pkg::*;
;
	localparam logic [7:0] A_CCS  = {IDX_CCS, 2'b00};
	localparam logic [7:0] A_TONE = {IDX_TONE, 2'b00};
	localparam logic [7:0] A_STAT = {IDX_INT_STAT, 2'b00};
	localparam logic [7:0] A_MASK = {IDX_INT_MASK, 2'b00};
	localparam int P[4] = '{20, 40, 100, 250};
	localparam int H[4] = '{0, 4, TONE_HALF2, TONE_HALF3};
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [3:0] b;
		logic [7:0] e;
		logic [7:0] m;
	} mct_row_t;
	// Write, then read back through the mask
	localparam mct_row_t ROWS[7] = '{
		'{A_CCS, 8'hF2, 4'h1, 8'hF2, 8'hFE}, '{A_TONE, 8'h03, 4'h1, 8'h03, 8'hFF},
		'{A_TONE, 8'h01, 4'h0, 8'h03, 8'hFF}, '{A_MASK, 8'h03, 4'h1, 8'h03, 8'hFF},
		'{8'hC0, 8'h55, 4'h1, 8'h00, 8'hFF}, '{A_TONE, 8'h00, 4'h1, 8'h00, 8'hFF},
		'{A_CCS, 8'h00, 4'h1, 8'h00, 8'hFE}};
	logic        sys_clk   = 1'b0;
	logic        rstn      = 1'b0;
	logic [7:0]  addr      = 8'h00;
	logic        rd        = 1'b0;
	logic        wr        = 1'b0;
	logic [31:0] wdata     = 32'h0000_0000;
	logic [3:0]  be        = 4'h0;
	logic        halt_exec = 1'b0;
	logic        wait_m    = 1'b0;
	logic        irq_mask  = 1'b0;
	logic        ext_wake  = 1'b0;
	logic [31:0] rdata;
	logic        wreq, core_tick, co_pin, co_oe, tone_pin, tone_oe, ahalt, halt, wake, irq;
	logic [15:0] clk_edges, tone_edges, tone_half;
	int          miscompares  = 0;
	int          total_checks = 0;
	int          cyc          = 0;

	// Slower tone halves left at their defaults so their real counts are exercised
	mct_top #(.TB_PERIOD0(20), .TB_PERIOD1(40), .TB_PERIOD2(100), .TB_PERIOD3(250),
		.TONE_HALF_1(4)) dut_u (
		.sys_clk_in(sys_clk), .rstn_in(rstn), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .halt_exec_in(halt_exec),
		.wait_in(wait_m), .irq_mask_in(irq_mask), .ext_wake_in(ext_wake),
		.core_tick_out(core_tick), .clock_out_pin_out(co_pin), .clock_out_pin_oe_out(co_oe),
		.tone_pin_out(tone_pin), .tone_pin_oe_out(tone_oe), .active_halt_out(ahalt),
		.halt_out(halt), .wake_out(wake), .irq_out(irq));
	mct_pin_monitor mon_u (.clk_in(sys_clk), .rstn_in(rstn), .clk_pin_in(co_pin & co_oe),
		.tone_pin_in(tone_pin & tone_oe), .clk_edges_out(clk_edges),
		.tone_edges_out(tone_edges), .tone_half_out(tone_half));

	always #50 sys_clk = ~sys_clk;
	// Ceiling well above the roughly 26000 cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (miscompares == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] b, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= {24'h00_0000, d};
		be    <= b;
		// No local limit: only the bench ceiling ends a hung request
		do begin
			@(posedge sys_clk);
			n++;
		end while (wreq !== 1'b0);
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		check(n, 2);
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, 4'h1, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, 4'h1, q);
		check(q & m, e & m);
	endtask
	// Irq may still stand from before a clear, so see it low first
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b0 && n < 1000) begin @(posedge sys_clk); n++; end
		while (irq !== 1'b1 && n < 1000) begin @(posedge sys_clk); n++; end
		if (n >= 1000) check(n, 0);
		t = cyc;
	endtask
	task automatic pulse_halt();
		@(posedge sys_clk);
		halt_exec <= 1'b1;
		@(posedge sys_clk);
		halt_exec <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic count_win(input int len, output int ticks, output int wakes);
		ticks = 0;
		wakes = 0;
		repeat (len) begin
			@(posedge sys_clk);
			if (core_tick === 1'b1) ticks++;
			if (wake === 1'b1) wakes++;
		end
	endtask

	initial begin
		int t0, t1, t2, tk, wk, pv;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (ROWS[i]) begin
			bus(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].b, t0[7:0]);
			rdc(ROWS[i].a, ROWS[i].e, ROWS[i].m);
		end
		wr8(A_STAT, 8'h03);
		for (int c = 0; c < 5; c++) begin
			wr8(A_CCS, c < 4 ? 8'(8'h90 | (c << 5)) : 8'h80);
			repeat (32) @(posedge sys_clk);
			t1 = clk_edges;
			count_win(64, tk, wk);
			pv = c < 4 ? 64 / (2 << c) : 64;
			check(tk, pv);
			check(clk_edges - t1, pv);
			check(co_oe, 1'b1);
		end
		for (int c = 1; c < 5; c++) begin
			wr8(A_TONE, 8'(c % 4));
			repeat (2 * H[c % 4] + 16) @(posedge sys_clk);
			check(tone_oe, c < 4);
			if (c < 4) check(tone_half, H[c]);
			else check(tone_pin, 1'b0);
		end
		wr8(A_TONE, 8'h01);
		wr8(A_CCS, 8'h82);
		wr8(A_STAT, 8'h01);
		wait_irq(t0);
		wr8(A_STAT, 8'h01);
		pulse_halt();
		check(ahalt, 1'b1);
		t1 = clk_edges;
		t2 = tone_edges;
		count_win(7, tk, wk);
		check(clk_edges - t1, 0);
		check(tone_edges > t2, 1);
		count_win(25, tk, wk);
		check(wk, 1);
		check(ahalt, 1'b0);
		wr8(A_CCS, 8'h80);
		pulse_halt();
		check(halt, 1'b1);
		t2 = tone_edges;
		repeat (300) @(posedge sys_clk);
		check(halt, 1'b1);
		check(tone_edges - t2, 0);
		ext_wake <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(halt, 1'b0);
		ext_wake <= 1'b0;
		wr8(A_CCS, 8'h02);
		wait_m <= 1'b1;
		count_win(41, tk, wk);
		check(wk, 2);
		wait_m <= 1'b0;
		wr8(A_STAT, 8'h03);
		wait_irq(t0);
		pv = 0;
		for (int k = 0; k < 4; k++) begin
			wr8(A_STAT, 8'h01);
			wr8(A_CCS, 8'(8'h02 | ((3 - k) << 2)));
			wait_irq(t1);
			check(t1 - t0, P[pv]);
			wr8(A_STAT, 8'h01);
			wait_irq(t2);
			check(t2 - t1, P[3 - k]);
			t0 = t2;
			pv = 3 - k;
		end
		wr8(A_STAT, 8'h01);
		wait_irq(t0);
		rdc(A_CCS, 8'h01, 8'h01);
		rdc(A_CCS, 8'h00, 8'h01);
		irq_mask <= 1'b1;
		wr8(A_STAT, 8'h01);
		t1 = 0;
		repeat (30) begin @(posedge sys_clk); if (irq !== 1'b0) t1++; end
		check(t1, 0);
		irq_mask <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check(irq, 1'b1);
		wr8(A_MASK, 8'h00);
		repeat (3) @(posedge sys_clk);
		check(irq, 1'b0);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rdc(A_CCS, CCS_RST, 8'hFF);
		rdc(A_TONE, TONE_RST, 8'hFF);
		check({co_oe, tone_oe, irq}, 3'b000);
		print_verdict();
	end
endmodule
